// ---- clkdist_pkg.sv ----
// Shared constants, types and register map for the clock distribution dividers
`default_nettype none
package clkdist_pkg;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int NUM_STAGES = 6;
  localparam int NUM_CHANNELS = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] CHAN0_OUTPUT_CTRL = 9'h192;
  localparam logic [ADDR_W-1:0] CHAN1_OUTPUT_CTRL = 9'h198;
  localparam logic [ADDR_W-1:0] CHAN2_OUTPUT_CTRL = 9'h19d;
  localparam logic [ADDR_W-1:0] CHAN3_OUTPUT_CTRL = 9'h1a2;
  localparam logic [ADDR_W-1:0] PRESCALER_RATIO = 9'h1e0;
  localparam logic [ADDR_W-1:0] DISTRIBUTION_SOURCE_SELECT = 9'h1e1;
  localparam logic [ADDR_W-1:0] SYNC_CONTROL = 9'h230;
  localparam logic [ADDR_W-1:0] DIST_STATUS = 9'h231;
  // Stage order: ch0, ch1, ch2 first, ch2 second, ch3 first, ch3 second
  localparam logic [ADDR_W-1:0] STAGE_COUNTS_OFS [NUM_STAGES] =
    '{9'h190, 9'h196, 9'h199, 9'h19b, 9'h19e, 9'h1a0};
  localparam logic [ADDR_W-1:0] STAGE_PHASE_OFS [NUM_STAGES] =
    '{9'h191, 9'h197, 9'h19a, 9'h19c, 9'h19f, 9'h1a1};
  localparam logic [ADDR_W-1:0] CHAN_CTRL_OFS [NUM_CHANNELS] =
    '{CHAN0_OUTPUT_CTRL, CHAN1_OUTPUT_CTRL, CHAN2_OUTPUT_CTRL, CHAN3_OUTPUT_CTRL};

  // Field positions
  localparam int LOW_MSB = 7;
  localparam int LOW_LSB = 4;
  localparam int HIGH_MSB = 3;
  localparam int HIGH_LSB = 0;
  localparam int BYPASS_BIT = 7;
  localparam int BEGIN_HIGH_BIT = 4;
  localparam int DELAY_MSB = 3;
  localparam int DELAY_LSB = 0;
  localparam int DUTY_FIX_DISABLE_BIT = 0;
  localparam int SECOND_DUTY_FIX_DISABLE_BIT = 1;
  localparam int DIRECT_ROUTE_BIT = 1;
  localparam int PRESC_MSB = 2;
  localparam int SOURCE_MSB = 1;
  localparam int SYNC_SOFT_BIT = 0;
  localparam int ST_FORBIDDEN_BIT = 4;
  localparam int ST_ROUTE_MISUSE_BIT = 5;
  localparam int ST_SYNC_BIT = 6;

  // Values after reset
  localparam logic [DATA_W-1:0] COUNTS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] PHASE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] PRESC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] SOURCE_RESET = 8'h02;
  localparam logic [DATA_W-1:0] SYNC_RESET = 8'h00;

  // Prescaler ratio = code + PRESC_BASE, codes above PRESC_MAX_CODE clamp
  localparam logic [2:0] PRESC_BASE = 3'h2;
  localparam logic [2:0] PRESC_MAX_CODE = 3'h4;
  // Outputs stay in sync this long after a source change
  localparam int SETTLE_NS = 400;
  localparam int CLK_PERIOD_NS = 40;
  localparam logic [3:0] SETTLE_CYCLES = 4'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    SRC_EXT_PRESC = 2'h0,
    SRC_EXT_DIRECT = 2'h1,
    SRC_OSC_PRESC = 2'h2,
    SRC_FORBIDDEN = 2'h3
  } source_sel_t;

  typedef enum logic [3:0] {
    ST_HOLD = 4'h1,
    ST_DELAY = 4'h2,
    ST_HIGH = 4'h4,
    ST_LOW = 4'h8
  } stage_state_t;

  typedef struct packed {
    logic bypass;
    logic duty_fix_disable;
    logic begin_at_high;
    logic [3:0] delay_cycles;
    logic [3:0] low_cnt;
    logic [3:0] high_cnt;
  } stage_cfg_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } clk_edge_t;

  typedef struct packed {
    logic pair0_a;
    logic pair0_b;
    logic pair1_a;
    logic pair1_b;
    logic chan2_first;
    logic chan2_second;
    logic chan3_first;
    logic chan3_second;
  } dist_out_t;

endpackage
`default_nettype wire

// ---- div_stage.sv ----
// One 2-to-32 divider stage with bypass, duty fix, coarse delay and start level
`default_nettype none
module div_stage
  import clkdist_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire clkdist_pkg::stage_cfg_t cfg,
  input wire clkdist_pkg::clk_edge_t in_clk,
  input wire logic sync_hold,
  output clkdist_pkg::clk_edge_t out_clk
);
  import clkdist_pkg::*;

  typedef struct packed {
    stage_state_t st;
    logic [4:0] cnt;
    logic level;
    logic drop_pending;
    logic rise;
    logic fall;
  } stage_reg_t;

  stage_reg_t s;
  stage_reg_t next_s;
  logic duty_fix;
  logic [4:0] delay_total;

  // Odd division with low = high + 1 only
  assign duty_fix = !cfg.duty_fix_disable &&
                    ({1'b0, cfg.low_cnt} == ({1'b0, cfg.high_cnt} + 5'h01));
  // Begin-high adds the low phase to the offset, max 31
  assign delay_total = {1'b0, cfg.delay_cycles} +
                       (cfg.begin_at_high ? ({1'b0, cfg.low_cnt} + 5'h01) : 5'h00);

  always_comb begin
    next_s = s;
    if (sync_hold) begin
      // Sync wins over bypass so that every divider output stays static
      next_s.st = ST_HOLD;
      next_s.cnt = 5'h00;
      next_s.drop_pending = 1'b0;
      next_s.level = cfg.begin_at_high;
    end else if (cfg.bypass) begin
      // Counters parked, input passed straight through
      next_s.st = ST_HOLD;
      next_s.cnt = 5'h00;
      next_s.drop_pending = 1'b0;
      next_s.level = in_clk.level;
    end else begin
      if (in_clk.fall && s.drop_pending) begin
        next_s.level = 1'b0;
        next_s.drop_pending = 1'b0;
      end
      unique case (s.st)
        ST_HOLD: begin
          // Restart from programmed offset after sync
          next_s.st = ST_DELAY;
          next_s.cnt = delay_total;
        end
        ST_DELAY: begin
          if (in_clk.rise) begin
            if (s.cnt == 5'h00) begin
              next_s.st = ST_HIGH;
              next_s.level = 1'b1;
              next_s.cnt = {1'b0, cfg.high_cnt};
            end else begin
              next_s.cnt = s.cnt - 5'h01;
            end
          end
        end
        ST_HIGH: begin
          if (in_clk.rise) begin
            if (s.cnt == 5'h00) begin
              // High for N+1 input cycles
              next_s.st = ST_LOW;
              next_s.cnt = {1'b0, cfg.low_cnt};
              if (duty_fix) begin
                next_s.drop_pending = 1'b1;
              end else begin
                next_s.level = 1'b0;
              end
            end else begin
              next_s.cnt = s.cnt - 5'h01;
            end
          end
        end
        ST_LOW: begin
          if (in_clk.rise) begin
            if (s.cnt == 5'h00) begin
              // Low for M+1 input cycles
              next_s.st = ST_HIGH;
              next_s.level = 1'b1;
              next_s.cnt = {1'b0, cfg.high_cnt};
            end else begin
              next_s.cnt = s.cnt - 5'h01;
            end
          end
        end
        default: begin
          next_s.st = ST_HOLD;
        end
      endcase
    end
    next_s.rise = next_s.level & ~s.level;
    next_s.fall = ~next_s.level & s.level;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
      s.st <= ST_HOLD;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign out_clk = '{level: s.level, rise: s.rise, fall: s.fall};

endmodule
`default_nettype wire

// ---- clock_distribution_dividers.sv ----
// Clock distribution: source select, prescaler, four channel dividers, registers
//
// Local design decision: strobed register access.
`default_nettype none
// Operation
// - Four channels; two single-divider channels, two with cascaded divider pairs.
// - Single divider divides 2 to 32, or bypassed for division of one.
// - Cascaded channel division is the product of its two stage divisions.
// - Prescaler divides by 2 to 6, chosen by prescaler_ratio bits 2:0.
// - Divider output high N+1 input cycles, low M+1, division N+M+2.
// - Duty fix gives 50 percent on odd division only when M equals N+1.
// - Coarse output delay in whole input cycles, up to 15.
// - Each divider output may begin high or begin low.
// - Source field: 00 external+prescaler, 01 external, 10 oscillator+prescaler, 11 banned.
// - Direct-route bits send the prescaler input to the first output pairs.
// - Total division is prescaler times channel; direct outputs see division one.
// - Bypass makes a channel divide by one and parks its divider.
// - Cascaded channels have two stages, each bypassable or 2 to 32.
// - Low and high count fields are four bits holding count minus one.
// - Duty fix on by default; a per-divider disable bit turns it off.
// - Delay and begin-high take effect only after an output sync.
module clock_distribution_dividers
  import clkdist_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic ext_clk_pin,
  input wire logic osc_clk_pin,
  input wire logic sync_req_n,
  input wire logic [clkdist_pkg::ADDR_W-1:0] addr,
  input wire logic [clkdist_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [clkdist_pkg::DATA_W-1:0] rdata,
  output clkdist_pkg::dist_out_t outs
);
  import clkdist_pkg::*;

  typedef struct packed {
    logic [NUM_STAGES-1:0][DATA_W-1:0] counts;
    logic [NUM_STAGES-1:0][DATA_W-1:0] phase;
    logic [NUM_CHANNELS-1:0][DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] presc;
    logic [DATA_W-1:0] source;
    logic [DATA_W-1:0] sync_ctrl;
    logic forbidden_seen;
    logic route_misuse_seen;
    logic [DATA_W-1:0] rdata;
    logic ext_meta;
    logic ext_sync;
    logic osc_meta;
    logic osc_sync;
    logic sync_meta_n;
    logic sync_pin_n;
    logic src_level;
    logic src_prev;
    logic [2:0] presc_cnt;
    logic presc_level;
    logic presc_rise;
    logic presc_fall;
    logic [3:0] settle;
    dist_out_t outs;
  } dist_reg_t;

  dist_reg_t s;
  dist_reg_t next_s;
  stage_cfg_t [NUM_STAGES-1:0] stage_cfg;
  clk_edge_t [NUM_STAGES-1:0] stage_in;
  clk_edge_t [NUM_STAGES-1:0] stage_out;
  clk_edge_t src_edge;
  clk_edge_t div_in;
  source_sel_t src_sel;
  logic [2:0] presc_ratio;
  logic [2:0] presc_half;
  logic uses_presc;
  logic src_ok;
  logic direct_req;
  logic sync_hold;
  logic [DATA_W-1:0] status_value;

  assign src_sel = source_sel_t'(s.source[SOURCE_MSB:0]);
  assign src_ok = (src_sel != SRC_FORBIDDEN);
  assign uses_presc = (src_sel == SRC_EXT_PRESC) || (src_sel == SRC_OSC_PRESC);
  // Ratio 2..6 from a three-bit code; codes beyond the table clamp at 6
  assign presc_ratio = (s.presc[PRESC_MSB:0] > PRESC_MAX_CODE) ?
                       (PRESC_MAX_CODE + PRESC_BASE) :
                       (s.presc[PRESC_MSB:0] + PRESC_BASE);
  assign presc_half = presc_ratio >> 1;
  assign direct_req = s.ctrl[0][DIRECT_ROUTE_BIT] || s.ctrl[1][DIRECT_ROUTE_BIT];

  // A banned code or a source change holds every divider in sync
  assign sync_hold = !s.sync_pin_n || s.sync_ctrl[SYNC_SOFT_BIT] ||
                     !src_ok || (s.settle != 4'h0);

  assign src_edge = '{level: s.src_level,
                      rise: s.src_level & ~s.src_prev,
                      fall: ~s.src_level & s.src_prev};
  assign div_in = uses_presc ?
                  '{level: s.presc_level, rise: s.presc_rise, fall: s.presc_fall} :
                  src_edge;

  // Stage configuration assembled from the raw register bytes
  always_comb begin
    for (int i = 0; i < NUM_STAGES; i++) begin
      stage_cfg[i].bypass = s.phase[i][BYPASS_BIT];
      stage_cfg[i].begin_at_high = s.phase[i][BEGIN_HIGH_BIT];
      stage_cfg[i].delay_cycles = s.phase[i][DELAY_MSB:DELAY_LSB];
      stage_cfg[i].low_cnt = s.counts[i][LOW_MSB:LOW_LSB];
      stage_cfg[i].high_cnt = s.counts[i][HIGH_MSB:HIGH_LSB];
    end
    stage_cfg[0].duty_fix_disable = s.ctrl[0][DUTY_FIX_DISABLE_BIT];
    stage_cfg[1].duty_fix_disable = s.ctrl[1][DUTY_FIX_DISABLE_BIT];
    stage_cfg[2].duty_fix_disable = s.ctrl[2][DUTY_FIX_DISABLE_BIT];
    stage_cfg[3].duty_fix_disable = s.ctrl[2][SECOND_DUTY_FIX_DISABLE_BIT];
    stage_cfg[4].duty_fix_disable = s.ctrl[3][DUTY_FIX_DISABLE_BIT];
    stage_cfg[5].duty_fix_disable = s.ctrl[3][SECOND_DUTY_FIX_DISABLE_BIT];
  end

  // Cascade: the second stage of each double channel counts the first
  always_comb begin
    stage_in[0] = div_in;
    stage_in[1] = div_in;
    stage_in[2] = div_in;
    stage_in[3] = stage_out[2];
    stage_in[4] = div_in;
    stage_in[5] = stage_out[4];
  end

  // Six stages: ch0, ch1 single; ch2, ch3 as cascaded pairs
  for (genvar g = 0; g < NUM_STAGES; g++) begin : g_stage
    div_stage u_stage (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .cfg(stage_cfg[g]),
      .in_clk(stage_in[g]),
      .sync_hold(sync_hold),
      .out_clk(stage_out[g])
    );
  end

  always_comb begin
    status_value = '0;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      status_value[i] = 1'b0;
    end
    status_value[0] = s.outs.pair0_a;
    status_value[1] = s.outs.pair1_a;
    status_value[2] = s.outs.chan2_first;
    status_value[3] = s.outs.chan3_first;
    status_value[ST_FORBIDDEN_BIT] = s.forbidden_seen;
    status_value[ST_ROUTE_MISUSE_BIT] = s.route_misuse_seen;
    status_value[ST_SYNC_BIT] = sync_hold;
  end

  always_comb begin
    next_s = s;

    // Pin synchronisers; only the second flop is read
    next_s.ext_meta = ext_clk_pin;
    next_s.ext_sync = s.ext_meta;
    next_s.osc_meta = osc_clk_pin;
    next_s.osc_sync = s.osc_meta;
    next_s.sync_meta_n = sync_req_n;
    next_s.sync_pin_n = s.sync_meta_n;

    // Source selection
    unique case (src_sel)
      SRC_EXT_PRESC: next_s.src_level = s.ext_sync;
      SRC_EXT_DIRECT: next_s.src_level = s.ext_sync;
      SRC_OSC_PRESC: next_s.src_level = s.osc_sync;
      SRC_FORBIDDEN: next_s.src_level = 1'b0;
    endcase
    next_s.src_prev = s.src_level;

    // Prescaler counts source rising edges
    next_s.presc_rise = 1'b0;
    next_s.presc_fall = 1'b0;
    if (!uses_presc) begin
      next_s.presc_cnt = 3'h0;
      next_s.presc_level = 1'b0;
    end else if (src_edge.rise) begin
      if (s.presc_cnt >= presc_ratio - 3'h1) begin
        next_s.presc_cnt = 3'h0;
      end else begin
        next_s.presc_cnt = s.presc_cnt + 3'h1;
      end
      next_s.presc_level = (next_s.presc_cnt < presc_half);
    end
    next_s.presc_rise = next_s.presc_level & ~s.presc_level;
    next_s.presc_fall = ~next_s.presc_level & s.presc_level;

    // Settle counter hides the glitch of a source switch
    if (s.settle != 4'h0) begin
      next_s.settle = s.settle - 4'h1;
    end

    // Register writes
    if (wr) begin
      for (int i = 0; i < NUM_STAGES; i++) begin
        if (addr == STAGE_COUNTS_OFS[i]) begin
          next_s.counts[i] = wdata;
        end
        if (addr == STAGE_PHASE_OFS[i]) begin
          next_s.phase[i] = wdata;
        end
      end
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        if (addr == CHAN_CTRL_OFS[i]) begin
          next_s.ctrl[i] = wdata;
        end
      end
      unique case (addr)
        PRESCALER_RATIO: next_s.presc = wdata;
        DISTRIBUTION_SOURCE_SELECT: begin
          next_s.source = wdata;
          if (wdata[SOURCE_MSB:0] != s.source[SOURCE_MSB:0]) begin
            next_s.settle = SETTLE_CYCLES;
          end
        end
        SYNC_CONTROL: next_s.sync_ctrl = wdata;
        DIST_STATUS: begin
          // Write one to clear the sticky flags
          if (wdata[ST_FORBIDDEN_BIT]) begin
            next_s.forbidden_seen = 1'b0;
          end
          if (wdata[ST_ROUTE_MISUSE_BIT]) begin
            next_s.route_misuse_seen = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Sticky flags; a new event wins over a clear in the same cycle
    if (!src_ok) begin
      next_s.forbidden_seen = 1'b1;
    end
    if (direct_req && !uses_presc) begin
      next_s.route_misuse_seen = 1'b1;
    end

    // Register reads, data valid the cycle after the strobe only
    next_s.rdata = '0;
    if (rd) begin
      for (int i = 0; i < NUM_STAGES; i++) begin
        if (addr == STAGE_COUNTS_OFS[i]) begin
          next_s.rdata = s.counts[i];
        end
        if (addr == STAGE_PHASE_OFS[i]) begin
          next_s.rdata = s.phase[i];
        end
      end
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        if (addr == CHAN_CTRL_OFS[i]) begin
          next_s.rdata = s.ctrl[i];
        end
      end
      unique case (addr)
        PRESCALER_RATIO: next_s.rdata = s.presc;
        DISTRIBUTION_SOURCE_SELECT: next_s.rdata = s.source;
        SYNC_CONTROL: next_s.rdata = s.sync_ctrl;
        DIST_STATUS: next_s.rdata = status_value;
        default: begin
        end
      endcase
    end

    // Outputs; direct route takes the prescaler input undivided
    // Direct route without prescaler source is held low, not passed through
    if (s.ctrl[0][DIRECT_ROUTE_BIT]) begin
      next_s.outs.pair0_a = uses_presc & s.src_level;
      next_s.outs.pair0_b = uses_presc & s.src_level;
    end else begin
      next_s.outs.pair0_a = stage_out[0].level;
      next_s.outs.pair0_b = stage_out[0].level;
    end
    if (s.ctrl[1][DIRECT_ROUTE_BIT]) begin
      next_s.outs.pair1_a = uses_presc & s.src_level;
      next_s.outs.pair1_b = uses_presc & s.src_level;
    end else begin
      next_s.outs.pair1_a = stage_out[1].level;
      next_s.outs.pair1_b = stage_out[1].level;
    end
    next_s.outs.chan2_first = stage_out[3].level;
    next_s.outs.chan2_second = stage_out[3].level;
    next_s.outs.chan3_first = stage_out[5].level;
    next_s.outs.chan3_second = stage_out[5].level;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
      for (int i = 0; i < NUM_STAGES; i++) begin
        s.counts[i] <= COUNTS_RESET;
        s.phase[i] <= PHASE_RESET;
      end
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        s.ctrl[i] <= CTRL_RESET;
      end
      s.presc <= PRESC_RESET;
      s.source <= SOURCE_RESET;
      s.sync_ctrl <= SYNC_RESET;
      s.sync_meta_n <= 1'b1;
      s.sync_pin_n <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign outs = s.outs;

endmodule
`default_nettype wire

// ---- clock_distribution_dividers_properties.sv ----
// Port-level properties of the clock distribution dividers
`default_nettype none
module clock_distribution_dividers_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic ext_clk_pin,
  input wire logic osc_clk_pin,
  input wire logic sync_req_n,
  input wire logic [clkdist_pkg::ADDR_W-1:0] addr,
  input wire logic [clkdist_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [clkdist_pkg::DATA_W-1:0] rdata,
  input wire clkdist_pkg::dist_out_t outs
);
  import clkdist_pkg::*;
  logic [2:0] presc_sh;
  logic [1:0] src_sh;
  logic route0;
  logic route1;
  logic forb;
  logic [4:0] quiet;
  logic [3:0] sync_cnt;
  // Quiet count restarts on any config change, so settle and sync windows are excluded
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      presc_sh <= PRESC_RESET[2:0];
      src_sh <= SOURCE_RESET[1:0];
      route0 <= 1'b0;
      route1 <= 1'b0;
      forb <= 1'b0;
    end else if (ce) begin
      if (wr && addr == PRESCALER_RATIO) presc_sh <= wdata[2:0];
      if (wr && addr == DISTRIBUTION_SOURCE_SELECT) src_sh <= wdata[1:0];
      if (wr && addr == CHAN0_OUTPUT_CTRL) route0 <= wdata[1];
      if (wr && addr == CHAN1_OUTPUT_CTRL) route1 <= wdata[1];
      if (src_sh == 2'h3 && quiet >= 5'd4) forb <= 1'b1;
      else if (wr && addr == DIST_STATUS && wdata[4]) forb <= 1'b0;
    end
    quiet <= (sys_rst || !ce || wr || !sync_req_n) ? 5'd0 : (quiet == 5'd31 ? quiet : quiet + 5'd1);
    sync_cnt <= (sys_rst || sync_req_n) ? 4'd0 : (sync_cnt == 4'd15 ? sync_cnt : sync_cnt + 4'd1);
  end

  a_reset_clear: assert property (@(posedge clk) $fell(sys_rst) && $past(ce) |-> outs == 8'h00 && rdata == 8'h00)
    else $error("outputs not clear after reset");
  a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
    $past(ce) && !$past(rd) |-> rdata == 8'h00) else $error("read data outside read slot");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (sys_rst)
    $past(ce) && $past(rd) && $past(addr) == 9'h000 |-> rdata == 8'h00) else $error("unmapped read");
  a_presc_readback: assert property (@(posedge clk) disable iff (sys_rst)
    $past(ce) && $past(rd) && $past(addr) == PRESCALER_RATIO |-> rdata[2:0] == presc_sh)
    else $error("prescaler code readback");
  a_source_readback: assert property (@(posedge clk) disable iff (sys_rst)
    $past(ce) && $past(rd) && $past(addr) == DISTRIBUTION_SOURCE_SELECT |-> rdata[1:0] == src_sh)
    else $error("source code readback");
  a_route_follow: assert property (@(posedge clk) disable iff (sys_rst)
    route0 && src_sh == 2'h0 && quiet >= 5'd20
    |-> outs.pair0_a == $past(ext_clk_pin, 4) && outs.pair0_b == $past(ext_clk_pin, 4))
    else $error("direct route does not follow source");
  a_route_low: assert property (@(posedge clk) disable iff (sys_rst)
    route0 && src_sh == 2'h1 && quiet >= 5'd20 |-> !outs.pair0_a && !outs.pair0_b)
    else $error("direct route active without prescaler source");
  a_forbidden_still: assert property (@(posedge clk) disable iff (sys_rst)
    src_sh == 2'h3 && quiet >= 5'd20 |-> $stable(outs)) else $error("outputs move on banned code");
  a_forbidden_flag: assert property (@(posedge clk) disable iff (sys_rst)
    $past(ce) && $past(rd) && $past(addr) == DIST_STATUS && forb |-> rdata[ST_FORBIDDEN_BIT])
    else $error("banned code not flagged");
  a_sync_still: assert property (@(posedge clk) disable iff (sys_rst)
    sync_cnt >= 4'd10 && !route0 && !route1 |-> $stable(outs)) else $error("outputs move in sync");
endmodule
`default_nettype wire

// ---- clock_distribution_dividers_test.sv ----
// Self-checking bench for the clock distribution dividers
`default_nettype none
module clock_distribution_dividers_test;
  timeunit 1ns;
  timeprecision 1ns;
  import clkdist_pkg::*;
  typedef struct {
    logic [1:0] src;
    logic [2:0] presc;
    int stage;
    logic [7:0] cnt;
    logic [7:0] ph;
    logic [7:0] ctl;
    int b;
    int hi;
    int lo;
  } row_t;
  // Source pin period 4 cycles, oscillator pin period 6 cycles
  row_t rows [16] = '{
    '{2'h1, 3'h0, 0, 8'h00, 8'h00, 8'h00, 7, 4, 4}, '{2'h1, 3'h0, 0, 8'h30, 8'h00, 8'h01, 7, 4, 16},
    '{2'h1, 3'h0, 0, 8'h12, 8'h00, 8'h01, 7, 12, 8}, '{2'h1, 3'h0, 0, 8'h21, 8'h00, 8'h00, 7, 10, 10},
    '{2'h1, 3'h0, 1, 8'hff, 8'h00, 8'h01, 5, 64, 64}, '{2'h1, 3'h0, 1, 8'h00, 8'h80, 8'h00, 4, 2, 2},
    '{2'h0, 3'h0, 0, 8'h00, 8'h80, 8'h00, 7, 4, 4}, '{2'h0, 3'h1, 0, 8'h00, 8'h80, 8'h00, 7, 4, 8},
    '{2'h0, 3'h2, 0, 8'h00, 8'h80, 8'h00, 7, 8, 8}, '{2'h0, 3'h3, 0, 8'h00, 8'h80, 8'h00, 7, 8, 12},
    '{2'h0, 3'h4, 0, 8'h00, 8'h80, 8'h00, 7, 12, 12}, '{2'h0, 3'h7, 0, 8'h00, 8'h80, 8'h00, 7, 12, 12},
    '{2'h0, 3'h2, 0, 8'h00, 8'h00, 8'h02, 6, 2, 2}, '{2'h2, 3'h0, 1, 8'h00, 8'h80, 8'h00, 5, 6, 6},
    '{2'h1, 3'h0, 2, 8'h10, 8'h00, 8'h01, 2, 12, 12}, '{2'h1, 3'h0, 5, 8'h00, 8'h80, 8'h00, 1, 4, 4}
  };
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic ext_clk_pin = 1'b0;
  logic osc_clk_pin = 1'b0;
  logic sync_req_n = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  dist_out_t outs;
  logic [1:0] ph_e = 2'h0;
  logic [2:0] ph_o = 3'h0;
  logic [7:0] v;
  int n_errors = 0;
  int comparisons = 0;
  int n;
  int m;

  clock_distribution_dividers u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .ext_clk_pin(ext_clk_pin), .osc_clk_pin(osc_clk_pin), .sync_req_n(sync_req_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .outs(outs));

  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    ph_e <= ph_e + 2'h1;
    ext_clk_pin <= ph_e[1];
    ph_o <= (ph_o == 3'h5) ? 3'h0 : ph_o + 3'h1;
    osc_clk_pin <= (ph_o < 3'h3);
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(logic [ADDR_W-1:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic do_reset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check(16'(outs), 16'h0000);
    check(16'(rdata), 16'h0000);
  endtask
  // Held well past the input synchronisers so the hold state is really reached
  task automatic do_sync();
    @(posedge clk);
    sync_req_n <= 1'b0;
    repeat (14) @(posedge clk);
    sync_req_n <= 1'b1;
    repeat (20) @(posedge clk);
  endtask
  task automatic wait_lvl(int b, logic lvl, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      #1;
      cnt++;
      if (cnt > 600) begin
        n_errors++;
        $display("CHECK FAILED at %0t: timeout got %h expected %h", $time, outs[b], lvl);
        tally_and_finish();
      end
    end while (outs[b] !== lvl);
  endtask
  // Gap from a rise of one output to the next rise of another, modulo an 8-cycle period
  task automatic gap(int a, int b, int exp);
    wait_lvl(a, 1'b0, n);
    wait_lvl(a, 1'b1, n);
    wait_lvl(b, 1'b0, n);
    wait_lvl(b, 1'b1, m);
    check(16'((n + m) % 8), 16'(exp));
  endtask

  initial begin
    do_reset();
    foreach (rows[i]) begin
      do_reset();
      wr_reg(DISTRIBUTION_SOURCE_SELECT, {6'h00, rows[i].src});
      wr_reg(PRESCALER_RATIO, {5'h00, rows[i].presc});
      wr_reg(STAGE_COUNTS_OFS[rows[i].stage], rows[i].cnt);
      wr_reg(STAGE_PHASE_OFS[rows[i].stage], rows[i].ph);
      n = rows[i].stage < 2 ? rows[i].stage : (rows[i].stage < 4 ? 2 : 3);
      wr_reg(CHAN_CTRL_OFS[n], rows[i].ctl);
      do_sync();
      wait_lvl(rows[i].b, 1'b0, n);
      wait_lvl(rows[i].b, 1'b1, n);
      wait_lvl(rows[i].b, 1'b0, n);
      wait_lvl(rows[i].b, 1'b1, m);
      check(16'(n), 16'(rows[i].hi));
      check(16'(m), 16'(rows[i].lo));
      $display("row %0d done", i);
    end
    do_reset();
    for (int i = 0; i < NUM_STAGES; i++) begin
      rd_reg(STAGE_COUNTS_OFS[i], v);
      check(16'(v), 16'(COUNTS_RESET));
      rd_reg(STAGE_PHASE_OFS[i], v);
      check(16'(v), 16'(PHASE_RESET));
    end
    rd_reg(DISTRIBUTION_SOURCE_SELECT, v);
    check(16'(v), 16'(SOURCE_RESET));
    // Frozen clock enable must swallow the write
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(PRESCALER_RATIO, 8'h04);
    ce <= 1'b1;
    rd_reg(PRESCALER_RATIO, v);
    check(16'(v), 16'(PRESC_RESET));
    wr_reg(9'h000, 8'hff);
    rd_reg(9'h000, v);
    check(16'(v), 16'h0000);
    @(posedge clk);
    addr <= PRESCALER_RATIO;
    wdata <= 8'h03;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(16'(rdata[2:0]), 16'h0003);
    @(posedge clk);
    #1;
    check(16'(rdata), 16'h0000);
    $display("register test done");
    wr_reg(DISTRIBUTION_SOURCE_SELECT, 8'h01);
    repeat (30) @(posedge clk);
    wr_reg(STAGE_PHASE_OFS[1], 8'h03);
    gap(7, 5, 0);
    do_sync();
    gap(7, 5, 4);
    wr_reg(STAGE_PHASE_OFS[1], 8'h10);
    do_sync();
    gap(7, 5, 4);
    $display("phase test done");
    wr_reg(CHAN0_OUTPUT_CTRL, 8'h02);
    repeat (30) @(posedge clk);
    check(16'(outs.pair0_a), 16'h0000);
    wr_reg(DISTRIBUTION_SOURCE_SELECT, 8'h03);
    repeat (30) @(posedge clk);
    rd_reg(DIST_STATUS, v);
    check(16'(v[ST_FORBIDDEN_BIT]), 16'h0001);
    $display("source test done");
    tally_and_finish();
  end
endmodule

bind clock_distribution_dividers clock_distribution_dividers_properties u_props (.clk(clk),
  .sys_rst(sys_rst), .ce(ce), .ext_clk_pin(ext_clk_pin), .osc_clk_pin(osc_clk_pin),
  .sync_req_n(sync_req_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .outs(outs));
`default_nettype wire
